/* adct_top.v */
`timescale 1ns/1ps
`include "adct_defines.vh"
module adct_top #(
  parameter HW_TRIGGERS = 15
) (
  // AHB-Lite slave
  input  wire                   hclk,
  input  wire                   hresetn,
  input  wire                   hsel,
  input  wire [7:0]             haddr,
  input  wire [1:0]             htrans,
  input  wire                   hwrite,
  input  wire [2:0]             hsize,
  input  wire [31:0]            hwdata,
  input  wire                   hready,
  output wire                   hreadyout,
  output wire                   hresp,
  output wire [31:0]            hrdata,
  // Conversion core
  input  wire                   conv_started,
  input  wire                   conv_done,
  input  wire [9:0]             conversion_result,
  input  wire [15:0]            filter_output,
  input  wire                   acc_load,
  input  wire [15:0]            acc_load_value,
  output wire                   conv_trigger,
  output wire [5:0]             positive_channel_select,
  // Hardware trigger sources, index 0 is code 00001
  input  wire [HW_TRIGGERS-1:0] hw_trigger_in,
  // Interrupt
  output wire                   irq
);

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  reg        wr_pend_reg;
  reg        rd_pend_reg;
  reg [7:0]  addr_reg;
  reg [31:0] hrdata_reg;
  reg [31:0] rd_mux;
  wire       addr_phase;
  wire       wr_en;
  wire       rd_en;

  // Reads spend one wait state because hrdata_reg captures rd_mux in the first data-phase cycle.
  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_en      = wr_pend_reg;
  assign rd_en      = rd_pend_reg;
  assign hreadyout  = !rd_pend_reg;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      rd_pend_reg <= addr_phase && !hwrite;
      if (addr_phase) begin
        addr_reg <= {haddr[7:2], 2'b00};
      end
      if (rd_pend_reg) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  reg [4:0] trig_sel_reg;
  reg [7:0] ctrl_reg;
  reg [5:0] pch_reg;
  reg [1:0] irq_mask_reg;
  wire       previous_source_select;
  wire       justification_bit;
  wire [2:0] calculation_mode;
  wire [2:0] threshold_interrupt_mode;

  assign previous_source_select   = ctrl_reg[`ADCT_CTRL_PSS_BIT];
  assign justification_bit        = ctrl_reg[`ADCT_CTRL_JUST_BIT];
  assign calculation_mode         = ctrl_reg[`ADCT_CTRL_CALC_LSB +: 3];
  assign threshold_interrupt_mode = ctrl_reg[`ADCT_CTRL_TMD_LSB +: 3];
  assign positive_channel_select  = pch_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_sel_reg <= `ADCT_RST_TRIG;
      ctrl_reg     <= `ADCT_RST_BYTE;
      pch_reg      <= 6'h00;
      irq_mask_reg <= 2'b00;
    end else if (wr_en) begin
      case (addr_reg)
        `ADCT_OFS_TRIG_SEL: begin
          trig_sel_reg <= hwdata[4:0];
        end
        `ADCT_OFS_CTRL: begin
          ctrl_reg <= hwdata[7:0];
        end
        `ADCT_OFS_PCH: begin
          pch_reg <= hwdata[5:0];
        end
        `ADCT_OFS_IRQ_MASK: begin
          irq_mask_reg <= hwdata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Sixteen-bit data registers
  // --------------------------------------------------------------------------
  wire [15:0] accumulator_value;
  wire [15:0] threshold_setpoint;
  wire [15:0] lower_threshold;
  wire [15:0] upper_threshold;

  adct_reg16 #(
    .RESET_VALUE (`ADCT_RST_WORD)
  ) u_acc (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .wr_high    (wr_en && (addr_reg == `ADCT_OFS_ACC_HIGH)),
    .wr_low     (wr_en && (addr_reg == `ADCT_OFS_ACC_LOW)),
    .wr_byte    (hwdata[7:0]),
    .load       (acc_load),
    .load_value (acc_load_value),
    .value      (accumulator_value)
  );

  adct_reg16 #(
    .RESET_VALUE (`ADCT_RST_WORD)
  ) u_stpt (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .wr_high    (wr_en && (addr_reg == `ADCT_OFS_STPT_HIGH)),
    .wr_low     (wr_en && (addr_reg == `ADCT_OFS_STPT_LOW)),
    .wr_byte    (hwdata[7:0]),
    .load       (1'b0),
    .load_value (`ADCT_RST_WORD),
    .value      (threshold_setpoint)
  );

  adct_reg16 #(
    .RESET_VALUE (`ADCT_RST_WORD)
  ) u_lth (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .wr_high    (wr_en && (addr_reg == `ADCT_OFS_LTH_HIGH)),
    .wr_low     (wr_en && (addr_reg == `ADCT_OFS_LTH_LOW)),
    .wr_byte    (hwdata[7:0]),
    .load       (1'b0),
    .load_value (`ADCT_RST_WORD),
    .value      (lower_threshold)
  );

  adct_reg16 #(
    .RESET_VALUE (`ADCT_RST_WORD)
  ) u_uth (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .wr_high    (wr_en && (addr_reg == `ADCT_OFS_UTH_HIGH)),
    .wr_low     (wr_en && (addr_reg == `ADCT_OFS_UTH_LOW)),
    .wr_byte    (hwdata[7:0]),
    .load       (1'b0),
    .load_value (`ADCT_RST_WORD),
    .value      (upper_threshold)
  );

  // --------------------------------------------------------------------------
  // Previous result capture
  // --------------------------------------------------------------------------
  wire [15:0] result_just;
  reg  [15:0] previous_result_reg;

  assign result_just = justification_bit ? {6'h00, conversion_result}
                                         : {conversion_result, 6'h00};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      previous_result_reg <= `ADCT_RST_WORD;
    end else if (conv_started) begin
      if (previous_source_select) begin
        previous_result_reg <= filter_output;
      end else begin
        previous_result_reg <= result_just;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Setpoint error and threshold compare
  // --------------------------------------------------------------------------
  reg  [15:0] err_next;
  reg  [15:0] setpoint_error_reg;
  reg         below_lower_flag_reg;
  reg         above_upper_flag_reg;
  reg         thr_hit;
  wire        below_next;
  wire        above_next;

  // The setpoint only enters the modes that subtract it.
  always @* begin
    case (calculation_mode)
      `ADCT_CALC_RES_PREV: begin
        err_next = result_just - previous_result_reg;
      end
      `ADCT_CALC_RES_STPT: begin
        err_next = result_just - threshold_setpoint;
      end
      `ADCT_CALC_FLT_STPT: begin
        err_next = filter_output - threshold_setpoint;
      end
      `ADCT_CALC_FLT_PREV: begin
        err_next = filter_output - previous_result_reg;
      end
      default: begin
        err_next = result_just - threshold_setpoint;
      end
    endcase
  end

  assign below_next = $signed(err_next) < $signed(lower_threshold);
  assign above_next = $signed(err_next) > $signed(upper_threshold);

  always @* begin
    case (threshold_interrupt_mode)
      `ADCT_TMD_NEVER:     thr_hit = 1'b0;
      `ADCT_TMD_BELOW:     thr_hit = below_next;
      `ADCT_TMD_NOT_BELOW: thr_hit = !below_next;
      `ADCT_TMD_OUTSIDE:   thr_hit = below_next || above_next;
      `ADCT_TMD_INSIDE:    thr_hit = !below_next && !above_next;
      `ADCT_TMD_NOT_ABOVE: thr_hit = !above_next;
      `ADCT_TMD_ABOVE:     thr_hit = above_next;
      default:             thr_hit = 1'b1;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setpoint_error_reg   <= `ADCT_RST_WORD;
      below_lower_flag_reg <= 1'b0;
      above_upper_flag_reg <= 1'b0;
    end else if (conv_done) begin
      setpoint_error_reg   <= err_next;
      below_lower_flag_reg <= below_next;
      above_upper_flag_reg <= above_next;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  reg  [1:0] irq_stat_reg;
  wire [1:0] irq_set;
  wire [1:0] irq_clr;

  assign irq_set[`ADCT_IRQ_THR_BIT]  = conv_done && thr_hit;
  assign irq_set[`ADCT_IRQ_DONE_BIT] = conv_done;
  assign irq_clr = (wr_en && (addr_reg == `ADCT_OFS_IRQ_STAT)) ? hwdata[1:0] : 2'b00;

  // A new event in the clearing cycle keeps its bit set.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= 2'b00;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // --------------------------------------------------------------------------
  // Conversion trigger
  // --------------------------------------------------------------------------
  wire [HW_TRIGGERS-1:0] hw_sync;
  reg  [HW_TRIGGERS-1:0] hw_prev_reg;
  reg                    conv_trigger_reg;
  reg                    trig_next;
  wire [HW_TRIGGERS-1:0] hw_rise;

  adct_sync2 #(
    .WIDTH (HW_TRIGGERS)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (hw_trigger_in),
    .sync_out (hw_sync)
  );

  assign hw_rise = hw_sync & ~hw_prev_reg;

  // Reserved codes fall to the default branch and never start a conversion.
  always @* begin
    trig_next = 1'b0;
    case (trig_sel_reg)
      `ADCT_TRIG_OFF: begin
        trig_next = 1'b0;
      end
      `ADCT_TRIG_WR_PCH: begin
        trig_next = wr_en && (addr_reg == `ADCT_OFS_PCH);
      end
      `ADCT_TRIG_RD_RESH: begin
        trig_next = rd_en && (addr_reg == `ADCT_OFS_RES_HIGH);
      end
      `ADCT_TRIG_RD_ERRH: begin
        trig_next = rd_en && (addr_reg == `ADCT_OFS_ERR_HIGH);
      end
      default: begin
        if (trig_sel_reg <= `ADCT_TRIG_HW_LAST) begin
          trig_next = hw_rise[trig_sel_reg[3:0] - 4'h1];
        end
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hw_prev_reg      <= {HW_TRIGGERS{1'b0}};
      conv_trigger_reg <= 1'b0;
    end else begin
      hw_prev_reg      <= hw_sync;
      conv_trigger_reg <= trig_next;
    end
  end

  assign conv_trigger = conv_trigger_reg;

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr_reg)
      `ADCT_OFS_PREV_LOW:  rd_mux[7:0] = previous_result_reg[7:0];
      `ADCT_OFS_PREV_HIGH: rd_mux[7:0] = previous_result_reg[15:8];
      `ADCT_OFS_ACC_HIGH:  rd_mux[7:0] = accumulator_value[15:8];
      `ADCT_OFS_ACC_LOW:   rd_mux[7:0] = accumulator_value[7:0];
      `ADCT_OFS_STPT_HIGH: rd_mux[7:0] = threshold_setpoint[15:8];
      `ADCT_OFS_STPT_LOW:  rd_mux[7:0] = threshold_setpoint[7:0];
      `ADCT_OFS_ERR_HIGH:  rd_mux[7:0] = setpoint_error_reg[15:8];
      `ADCT_OFS_ERR_LOW:   rd_mux[7:0] = setpoint_error_reg[7:0];
      `ADCT_OFS_LTH_HIGH:  rd_mux[7:0] = lower_threshold[15:8];
      `ADCT_OFS_LTH_LOW:   rd_mux[7:0] = lower_threshold[7:0];
      `ADCT_OFS_UTH_HIGH:  rd_mux[7:0] = upper_threshold[15:8];
      `ADCT_OFS_UTH_LOW:   rd_mux[7:0] = upper_threshold[7:0];
      `ADCT_OFS_TRIG_SEL:  rd_mux[4:0] = trig_sel_reg;
      `ADCT_OFS_CTRL:      rd_mux[7:0] = ctrl_reg;
      `ADCT_OFS_PCH:       rd_mux[5:0] = pch_reg;
      `ADCT_OFS_RES_HIGH:  rd_mux[7:0] = result_just[15:8];
      `ADCT_OFS_RES_LOW:   rd_mux[7:0] = result_just[7:0];
      `ADCT_OFS_STATUS: begin
        rd_mux[`ADCT_STAT_BELOW_BIT] = below_lower_flag_reg;
        rd_mux[`ADCT_STAT_ABOVE_BIT] = above_upper_flag_reg;
      end
      `ADCT_OFS_IRQ_STAT:  rd_mux[1:0] = irq_stat_reg;
      `ADCT_OFS_IRQ_MASK:  rd_mux[1:0] = irq_mask_reg;
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

endmodule

/* adct_defines.vh */
`ifndef ADCT_DEFINES_VH
`define ADCT_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ADCT_OFS_PREV_LOW       8'h00
`define ADCT_OFS_PREV_HIGH      8'h04
`define ADCT_OFS_ACC_HIGH       8'h08
`define ADCT_OFS_ACC_LOW        8'h0C
`define ADCT_OFS_STPT_HIGH      8'h10
`define ADCT_OFS_STPT_LOW       8'h14
`define ADCT_OFS_ERR_HIGH       8'h18
`define ADCT_OFS_ERR_LOW        8'h1C
`define ADCT_OFS_LTH_HIGH       8'h20
`define ADCT_OFS_LTH_LOW        8'h24
`define ADCT_OFS_UTH_HIGH       8'h28
`define ADCT_OFS_UTH_LOW        8'h2C
`define ADCT_OFS_TRIG_SEL       8'h30
`define ADCT_OFS_CTRL           8'h34
`define ADCT_OFS_PCH            8'h38
`define ADCT_OFS_RES_HIGH       8'h3C
`define ADCT_OFS_RES_LOW        8'h40
`define ADCT_OFS_STATUS         8'h44
`define ADCT_OFS_IRQ_STAT       8'h48
`define ADCT_OFS_IRQ_MASK       8'h4C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define ADCT_CTRL_PSS_BIT       0
`define ADCT_CTRL_JUST_BIT      1
`define ADCT_CTRL_CALC_LSB      2
`define ADCT_CTRL_TMD_LSB       5
`define ADCT_STAT_BELOW_BIT     0
`define ADCT_STAT_ABOVE_BIT     1
`define ADCT_IRQ_THR_BIT        0
`define ADCT_IRQ_DONE_BIT       1
`define ADCT_RST_BYTE           8'h00
`define ADCT_RST_WORD           16'h0000
`define ADCT_RST_TRIG           5'h00

// ----------------------------------------------------------------------------
// Trigger select codes
// ----------------------------------------------------------------------------
`define ADCT_TRIG_OFF           5'h00
`define ADCT_TRIG_HW_LAST       5'h0F
`define ADCT_TRIG_RD_ERRH       5'h1C
`define ADCT_TRIG_RD_RESH       5'h1D
`define ADCT_TRIG_WR_PCH        5'h1F

// ----------------------------------------------------------------------------
// Calculation modes
// ----------------------------------------------------------------------------
`define ADCT_CALC_RES_PREV      3'h0
`define ADCT_CALC_RES_STPT      3'h1
`define ADCT_CALC_FLT_STPT      3'h2
`define ADCT_CALC_FLT_PREV      3'h3

// ----------------------------------------------------------------------------
// Threshold interrupt modes
// ----------------------------------------------------------------------------
`define ADCT_TMD_NEVER          3'h0
`define ADCT_TMD_BELOW          3'h1
`define ADCT_TMD_NOT_BELOW      3'h2
`define ADCT_TMD_OUTSIDE        3'h3
`define ADCT_TMD_INSIDE         3'h4
`define ADCT_TMD_NOT_ABOVE      3'h5
`define ADCT_TMD_ABOVE          3'h6
`define ADCT_TMD_ALWAYS         3'h7

`endif

/* adct_sync2.v */
`timescale 1ns/1ps
module adct_sync2 #(
  parameter WIDTH = 15
) (
  // Clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // Data
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule

/* adct_reg16.v */
`timescale 1ns/1ps
module adct_reg16 #(
  parameter [15:0] RESET_VALUE = 16'h0000
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // Byte writes from software
  input  wire        wr_high,
  input  wire        wr_low,
  input  wire [7:0]  wr_byte,
  // Whole-word load from hardware
  input  wire        load,
  input  wire [15:0] load_value,
  // Stored value
  output wire [15:0] value
);

  reg [15:0] value_reg;

  // A software byte write wins over a hardware load in the same cycle.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_reg <= RESET_VALUE;
    end else if (wr_high || wr_low) begin
      if (wr_high) begin
        value_reg[15:8] <= wr_byte;
      end
      if (wr_low) begin
        value_reg[7:0] <= wr_byte;
      end
    end else if (load) begin
      value_reg <= load_value;
    end
  end

  assign value = value_reg;

endmodule

/* adct_props.sv */
`timescale 1ns/1ps
`include "adct_defines.vh"
module adct_props #(
  parameter HW_TRIGGERS = 15
) (
  // Bus
  input wire                   hclk,
  input wire                   hresetn,
  input wire                   hsel,
  input wire [7:0]             haddr,
  input wire [1:0]             htrans,
  input wire                   hwrite,
  input wire [2:0]             hsize,
  input wire [31:0]            hwdata,
  input wire                   hready,
  input wire                   hreadyout,
  input wire                   hresp,
  input wire [31:0]            hrdata,
  // Core
  input wire                   conv_started,
  input wire                   conv_done,
  input wire [9:0]             conversion_result,
  input wire [15:0]            filter_output,
  input wire                   acc_load,
  input wire [15:0]            acc_load_value,
  input wire                   conv_trigger,
  input wire [5:0]             positive_channel_select,
  // Triggers and interrupt
  input wire [HW_TRIGGERS-1:0] hw_trigger_in,
  input wire                   irq
);
  // ----------------
  // Bus mirror
  // ----------------
  // Only the fields that steer triggers and interrupts are mirrored.
  logic       dp_vld;
  logic       dp_wr;
  logic [7:0] dp_adr;
  logic [4:0] sel_q;
  logic [7:0] ctl_q;
  logic [1:0] msk_q;
  wire        wr_done  = dp_vld && dp_wr && hready;
  wire        rd_first = dp_vld && !dp_wr && !hreadyout;
  wire        rd_done  = dp_vld && !dp_wr && hready;
  wire        hw_pick  = (sel_q != 5'h00 && sel_q <= 5'h0F) ? hw_trigger_in[sel_q - 5'h01] : 1'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_vld <= 1'h0;
      dp_wr  <= 1'h0;
      dp_adr <= 8'h00;
      sel_q  <= 5'h00;
      ctl_q  <= 8'h00;
      msk_q  <= 2'h0;
    end else begin
      if (hready) begin
        dp_vld <= hsel && htrans[1];
        dp_wr  <= hwrite;
        dp_adr <= haddr;
      end
      if (wr_done && dp_adr == `ADCT_OFS_TRIG_SEL) sel_q <= hwdata[4:0];
      if (wr_done && dp_adr == `ADCT_OFS_CTRL) ctl_q <= hwdata[7:0];
      if (wr_done && dp_adr == `ADCT_OFS_IRQ_MASK) msk_q <= hwdata[1:0];
    end
  end

  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_pulse;
    conv_trigger ##1 !conv_trigger;
  endsequence

  chk_resp_okay: assert property (hresp == 1'h0)
    else $error("bus response not OKAY");
  chk_read_wait: assert property (s_rd_taken |=> s_rd_answer)
    else $error("read data phase not one wait state");
  chk_pch_write_trig: assert property (
    (wr_done && dp_adr == `ADCT_OFS_PCH && sel_q == 5'h1F) |=> s_pulse)
    else $error("channel write did not trigger");
  chk_resh_read_trig: assert property (
    (rd_first && dp_adr == `ADCT_OFS_RES_HIGH && sel_q == 5'h1D) |-> ##[1:2] conv_trigger)
    else $error("result high read did not trigger");
  chk_errh_read_trig: assert property (
    (rd_first && dp_adr == `ADCT_OFS_ERR_HIGH && sel_q == 5'h1C) |-> ##[1:2] conv_trigger)
    else $error("error high read did not trigger");
  chk_hw_edge_trig: assert property (
    ($rose(hw_pick) && $stable(sel_q)) |-> ##[2:5] conv_trigger)
    else $error("selected source edge did not trigger");
  chk_off_quiet: assert property (
    (sel_q == 5'h00 && $past(sel_q) == 5'h00 && $past(sel_q, 2) == 5'h00) |-> !conv_trigger)
    else $error("trigger while external triggering off");
  chk_sel_readback: assert property (
    (rd_done && dp_adr == `ADCT_OFS_TRIG_SEL) |-> hrdata == {27'h0, sel_q})
    else $error("trigger select read back wrong");
  chk_irq_needs_mask: assert property (irq |-> msk_q != 2'h0)
    else $error("interrupt with all sources masked");
  chk_irq_always_mode: assert property (
    (conv_done && msk_q[0] && ctl_q[7:5] == `ADCT_TMD_ALWAYS) |=> irq)
    else $error("interrupt missing in always mode");
  chk_irq_never_mode: assert property (
    (conv_done && msk_q == 2'h1 && ctl_q[7:5] == `ADCT_TMD_NEVER && !irq) |=> !irq)
    else $error("interrupt raised in never mode");
  chk_reset_idle: assert property (
    $rose(hresetn) |-> (!irq && !conv_trigger && hreadyout))
    else $error("outputs not idle after reset");
endmodule

bind adct_top adct_props #(.HW_TRIGGERS(HW_TRIGGERS)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_started(conv_started),
  .conv_done(conv_done), .conversion_result(conversion_result),
  .filter_output(filter_output), .acc_load(acc_load), .acc_load_value(acc_load_value),
  .conv_trigger(conv_trigger), .positive_channel_select(positive_channel_select),
  .hw_trigger_in(hw_trigger_in), .irq(irq)
);

/* adct_top_tb.sv */
`timescale 1ns/1ps
`include "adct_defines.vh"
module adct_top_tb;
  // ----------------
  // Signals
  // ----------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire         hready;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  logic        conv_started;
  logic        conv_done;
  logic [9:0]  conversion_result;
  logic [15:0] filter_output;
  logic        acc_load;
  logic [15:0] acc_load_value;
  wire         conv_trigger;
  wire  [5:0]  positive_channel_select;
  logic [14:0] hw_trigger_in;
  wire         irq;
  int          bad_count = 0;
  int          checks = 0;
  int          trig_cnt = 0;
  int          c0;
  logic [31:0] rdv;
  logic [7:0]  ctl_t [4] = '{8'h06, 8'h0A, 8'h02, 8'h0E};
  logic [9:0]  res_t [4] = '{10'h050, 10'h050, 10'h060, 10'h050};
  logic [15:0] err_t [4] = '{16'hFF50, 16'h0100, 16'h0010, 16'h01B0};
  logic [7:0]  sta_t [4] = '{8'h01, 8'h02, 8'h00, 8'h02};
  logic [4:0]  sw_t [4]  = '{5'h1F, 5'h1D, 5'h1C, 5'h00};

  assign hready = hreadyout;

  adct_top #(.HW_TRIGGERS(15)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_started(conv_started),
    .conv_done(conv_done), .conversion_result(conversion_result),
    .filter_output(filter_output), .acc_load(acc_load), .acc_load_value(acc_load_value),
    .conv_trigger(conv_trigger), .positive_channel_select(positive_channel_select),
    .hw_trigger_in(hw_trigger_in), .irq(irq)
  );

  initial begin
    hclk = 1'h0;
    forever #25 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (conv_trigger === 1'h1) trig_cnt <= trig_cnt + 1;
  end

  // ----------------
  // Tasks
  // ----------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The master never assumes a latency: it waits on hready at each phase.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'h1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, {24'h000000, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'h0, a, 32'h00000000);
    check(rdv, {24'h000000, exp});
  endtask

  task automatic evt(input logic s, input logic d);
    conv_started <= s;
    conv_done    <= d;
    @(posedge hclk);
    conv_started <= 1'h0;
    conv_done    <= 1'h0;
    @(posedge hclk);
  endtask

  // The result changes between start and done so a previous-based mode sees a difference.
  task automatic run(input logic [7:0] ctl, input logic [9:0] r0, input logic [9:0] r1);
    wr(`ADCT_OFS_CTRL, ctl);
    conversion_result <= r0;
    filter_output     <= 16'hA55A;
    evt(1'h1, 1'h0);
    conversion_result <= r1;
    filter_output     <= 16'h0200;
    evt(1'h0, 1'h1);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    results();
  end

  // ----------------
  // Tests
  // ----------------
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    conv_started = 1'h0;
    conv_done = 1'h0;
    conversion_result = 10'h000;
    filter_output = 16'h0000;
    acc_load = 1'h0;
    acc_load_value = 16'h0000;
    hw_trigger_in = 15'h0000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(`ADCT_OFS_TRIG_SEL, 8'h00);
    wr(`ADCT_OFS_TRIG_SEL, 8'hEF);
    rd(`ADCT_OFS_TRIG_SEL, 8'h0F);
    wr(`ADCT_OFS_TRIG_SEL, 8'h00);
    wr(`ADCT_OFS_ACC_HIGH, 8'hC3);
    wr(`ADCT_OFS_ACC_LOW, 8'h5A);
    rd(`ADCT_OFS_ACC_HIGH, 8'hC3);
    rd(`ADCT_OFS_ACC_LOW, 8'h5A);
    acc_load_value <= 16'h8421;
    acc_load <= 1'h1;
    @(posedge hclk);
    acc_load <= 1'h0;
    @(posedge hclk);
    rd(`ADCT_OFS_ACC_HIGH, 8'h84);
    rd(`ADCT_OFS_ACC_LOW, 8'h21);
    run(8'h01, 10'h2B7, 10'h2B7);
    rd(`ADCT_OFS_PREV_HIGH, 8'hA5);
    rd(`ADCT_OFS_PREV_LOW, 8'h5A);
    run(8'h02, 10'h2B7, 10'h2B7);
    rd(`ADCT_OFS_PREV_HIGH, 8'h02);
    rd(`ADCT_OFS_PREV_LOW, 8'hB7);
    run(8'h00, 10'h2B7, 10'h2B7);
    rd(`ADCT_OFS_PREV_HIGH, 8'hAD);
    rd(`ADCT_OFS_PREV_LOW, 8'hC0);
    wr(`ADCT_OFS_STPT_HIGH, 8'h01);
    wr(`ADCT_OFS_STPT_LOW, 8'h00);
    wr(`ADCT_OFS_LTH_HIGH, 8'hFF);
    wr(`ADCT_OFS_LTH_LOW, 8'hA0);
    wr(`ADCT_OFS_UTH_HIGH, 8'h00);
    wr(`ADCT_OFS_UTH_LOW, 8'h10);
    for (int i = 0; i < 4; i++) begin
      run(ctl_t[i], 10'h050, res_t[i]);
      rd(`ADCT_OFS_ERR_HIGH, err_t[i][15:8]);
      rd(`ADCT_OFS_ERR_LOW, err_t[i][7:0]);
      rd(`ADCT_OFS_STATUS, sta_t[i]);
    end
    wr(`ADCT_OFS_IRQ_MASK, 8'h01);
    for (int t = 0; t < 8; t++) begin
      wr(`ADCT_OFS_IRQ_STAT, 8'h03);
      run({t[2:0], 5'h06}, 10'h050, 10'h050);
      rd(`ADCT_OFS_IRQ_STAT, {6'h00, 1'h1, t[0]});
      check({31'h0, irq}, {31'h0, t[0]});
    end
    wr(`ADCT_OFS_IRQ_STAT, 8'h03);
    rd(`ADCT_OFS_IRQ_STAT, 8'h00);
    wr(`ADCT_OFS_IRQ_MASK, 8'h02);
    evt(1'h0, 1'h1);
    check({31'h0, irq}, 32'h1);
    wr(`ADCT_OFS_IRQ_STAT, 8'h02);
    @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`ADCT_OFS_TRIG_SEL, {3'h0, sw_t[i]});
      for (int j = 0; j < 3; j++) begin
        c0 = trig_cnt;
        if (j == 0) wr(`ADCT_OFS_PCH, 8'h25);
        else bus(1'h0, (j == 1) ? `ADCT_OFS_RES_HIGH : `ADCT_OFS_ERR_HIGH, 32'h0);
        repeat (3) @(posedge hclk);
        check(trig_cnt - c0, {31'h0, i == j});
      end
    end
    check({26'h0, positive_channel_select}, 32'h25);
    for (int k = 1; k < 16; k++) begin
      wr(`ADCT_OFS_TRIG_SEL, k[7:0]);
      c0 = trig_cnt;
      hw_trigger_in <= 15'h0001 << (k % 15);
      repeat (8) @(posedge hclk);
      check(trig_cnt - c0, 32'h0);
      hw_trigger_in <= hw_trigger_in | (15'h0001 << (k - 1));
      repeat (8) @(posedge hclk);
      check(trig_cnt - c0, 32'h1);
      hw_trigger_in <= 15'h0000;
      repeat (8) @(posedge hclk);
    end
    wr(`ADCT_OFS_TRIG_SEL, 8'h00);
    c0 = trig_cnt;
    hw_trigger_in <= 15'h7FFF;
    repeat (8) @(posedge hclk);
    check(trig_cnt - c0, 32'h0);
    results();
  end
endmodule
